// ### verilog/sigma_delta_adc_control.sv
// digital control of the delta-sigma converter with an ahb-lite slave
//
// Overview of operation
// - ratio 000 divides by 30, 010 by 12
// - negative buffer bit: 0 bypass, 1 buffer on
// - positive buffer bit: 0 bypass, 1 buffer on
// - hold bit freezes result registers against new results
// - held: converter runs, done flag stays unchanged
// - hardware sets done flag, only software clears it
// - word rate: master clock over ratio times osr
// - source divider k gives 2(k+1), 11111 bypasses
// - power-off bit forces full power-down mode
// - sleep keeps bandgap, amp, filter; rest off
// - reset bit holds filter in reset, analog on
// - conversions begin only after reset bit falls
// - unheld results overwrite registers every conversion
// - reference bit selects internal or external pair
// - results are 24-bit two's complement signed
// - temp sensor powered only when channel selects it
// - reset bit aborts conversion, partial result dropped
// - osr codes 0..8 give 32768 down to 128
// - out-of-range results saturate, never wrap
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_map.svh"
module sigma_delta_adc_control #(
   parameter int DIV_W = 6,
   parameter int OSR_W = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire sdadc_pkg::ahb_req_t ahb_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic mod_bit_i,
   output sdadc_pkg::analog_ctrl_t analog_o,
   output logic result_valid_o,
   output logic [23:0] result_o
);
   import sdadc_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] channel_sel_ff;
   logic [7:0] control_zero_ff;
   logic [7:0] control_one_ff;
   logic [7:0] clock_divider_ff;
   logic [7:0] reserved_tuning_ff;
   logic [23:0] result_ff;
   logic [7:0] wr_idx_ff;
   logic wr_pend_ff;
   logic [31:0] hrdata_ff;
   logic [2:0] bit_sync_ff;
   logic mod_bit_ff;
   logic soft_reset_prev_ff;
   logic started_ff;
   logic [OSR_W-1:0] osr_cnt_ff;
   logic signed [17:0] acc_ff;
   logic result_valid_ff;
   analog_ctrl_t analog_ff;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire logic addr_phase = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1] &
      ce_i;
   wire logic [7:0] req_idx = ahb_i.haddr[9:2];
   wire logic idx_hit = (ahb_i.haddr[31:10] == 22'h0) &
      (ahb_i.haddr[1:0] == 2'h0);
   wire logic wr_en = wr_pend_ff & ce_i;
   wire logic [7:0] wdata = ahb_i.hwdata[7:0];
   wire logic wr_chan = wr_en & (wr_idx_ff == `IDX_CHANNEL_SEL);
   wire logic wr_ctl0 = wr_en & (wr_idx_ff == `IDX_CONTROL_ZERO);
   wire logic wr_ctl1 = wr_en & (wr_idx_ff == `IDX_CONTROL_ONE);
   wire logic wr_cdiv = wr_en & (wr_idx_ff == `IDX_CLOCK_DIVIDER);
   wire logic wr_tune = wr_en & (wr_idx_ff == `IDX_RESERVED_TUNING);

   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (!idx_hit) begin
         rd_byte = 8'h00;
      end else if (req_idx == `IDX_CHANNEL_SEL) begin
         rd_byte = channel_sel_ff;
      end else if (req_idx == `IDX_RESULT_LOW) begin
         rd_byte = result_ff[7:0];
      end else if (req_idx == `IDX_RESULT_MID) begin
         rd_byte = result_ff[15:8];
      end else if (req_idx == `IDX_RESULT_HIGH) begin
         rd_byte = result_ff[23:16];
      end else if (req_idx == `IDX_CONTROL_ZERO) begin
         rd_byte = control_zero_ff;
      end else if (req_idx == `IDX_CONTROL_ONE) begin
         rd_byte = control_one_ff;
      end else if (req_idx == `IDX_CLOCK_DIVIDER) begin
         rd_byte = clock_divider_ff;
      end else if (req_idx == `IDX_RESERVED_TUNING) begin
         rd_byte = reserved_tuning_ff;
      end
   end
   wire logic [31:0] nxt_hrdata = (addr_phase & !ahb_i.hwrite) ?
      {24'h000000, rd_byte} : 32'h00000000;

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   wire logic soft_reset = control_zero_ff[`CZ_SOFT_RESET];
   wire logic sleep_bit = control_zero_ff[`CZ_SLEEP];
   wire logic power_off = control_zero_ff[`CZ_POWER_OFF];
   wire logic [3:0] osr_code = control_zero_ff[`CZ_OSR_HI:`CZ_OSR_LO];
   wire logic [2:0] flms = control_one_ff[`CO_FLMS_HI:`CO_FLMS_LO];
   wire logic hold = control_one_ff[`CO_HOLD];
   wire logic done_flag = control_one_ff[`CO_DONE];
   wire logic neg_buf = control_one_ff[`CO_NEG_BUF];
   wire logic pos_buf = control_one_ff[`CO_POS_BUF];
   wire logic [4:0] src_div = clock_divider_ff[4:0];
   wire logic [2:0] neg_ch = channel_sel_ff[`CH_NEG_HI:`CH_NEG_LO];
   wire logic [2:0] pos_ch = channel_sel_ff[`CH_POS_HI:`CH_POS_LO];

   // ----------------------------------------------------------------
   // operating mode
   // ----------------------------------------------------------------
   wire conv_mode_t mode = power_off ? MODE_POWER_DOWN :
      sleep_bit ? MODE_SLEEP :
      soft_reset ? MODE_RESET : MODE_NORMAL;
   wire logic temp_sel = (pos_ch == `CH_TEMP_SENSOR) |
      (neg_ch == `CH_TEMP_SENSOR);

   analog_ctrl_t nxt_analog;
   always_comb begin
      nxt_analog = '0;
      nxt_analog.reference_pair_sel = control_zero_ff[`CZ_REF_SEL];
      case (mode)
         MODE_POWER_DOWN: begin
            nxt_analog.neg_ref_bypass = 1'b1;
            nxt_analog.pos_ref_bypass = 1'b1;
         end
         MODE_SLEEP: begin
            nxt_analog.bandgap_en = 1'b1;
            nxt_analog.amp_en = 1'b1;
            nxt_analog.filter_en = 1'b1;
            nxt_analog.neg_ref_bypass = 1'b1;
            nxt_analog.pos_ref_bypass = 1'b1;
         end
         default: begin
            nxt_analog.bandgap_en = 1'b1;
            nxt_analog.amp_en = 1'b1;
            nxt_analog.modulator_en = 1'b1;
            nxt_analog.temp_sensor_en = temp_sel;
            nxt_analog.neg_ref_buffer_en = neg_buf;
            nxt_analog.neg_ref_bypass = !neg_buf;
            nxt_analog.pos_ref_buffer_en = pos_buf;
            nxt_analog.pos_ref_bypass = !pos_buf;
            nxt_analog.filter_en = 1'b1;
            nxt_analog.filter_reset = (mode == MODE_RESET);
         end
      endcase
   end

   // ----------------------------------------------------------------
   // clock dividers
   // ----------------------------------------------------------------
   wire logic flms_ok = (flms == `FLMS_DIV30) | (flms == `FLMS_DIV12);
   wire logic osr_ok = (osr_code <= `OSR_MAX_CODE);
   wire logic mod_on = ((mode == MODE_NORMAL) | (mode == MODE_RESET)) &
      flms_ok & osr_ok;
   wire logic [DIV_W-1:0] src_ratio = (src_div == `SRC_BYPASS) ?
      DIV_W'(1) : DIV_W'({src_div, 1'b0} + 6'h02);
   wire logic [DIV_W-1:0] flms_ratio = (flms == `FLMS_DIV12) ?
      DIV_W'(`RATIO_12) : DIV_W'(`RATIO_30);
   logic mclk_tick;
   logic mod_tick;

   tick_divider #(.W(DIV_W)) u_src_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .run_i(mod_on),
      .advance_i(1'b1),
      .ratio_i(src_ratio),
      .tick_o(mclk_tick)
   );

   tick_divider #(.W(DIV_W)) u_flms_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .run_i(mod_on),
      .advance_i(mclk_tick),
      .ratio_i(flms_ratio),
      .tick_o(mod_tick)
   );

   // ----------------------------------------------------------------
   // decimation filter
   // ----------------------------------------------------------------
   wire logic nxt_mod_bit = (bit_sync_ff[1] == bit_sync_ff[2]) ?
      bit_sync_ff[2] : mod_bit_ff;
   wire logic soft_reset_fall = soft_reset_prev_ff & !soft_reset;
   wire logic nxt_started = power_off ? 1'b0 :
      soft_reset_fall ? 1'b1 : started_ff;
   wire logic filt_run = (mode == MODE_NORMAL) & started_ff &
      mod_on;
   wire logic step = filt_run & mod_tick;
   wire logic [OSR_W-1:0] osr_last = (OSR_W'(`OSR_TOP) >> osr_code) -
      OSR_W'(1);
   wire logic osr_end = (osr_cnt_ff == osr_last);
   wire logic signed [17:0] acc_step = mod_bit_ff ? acc_ff + 18'sd1 :
      acc_ff - 18'sd1;
   wire logic [4:0] shift = `SHIFT_BASE + {1'b0, osr_code};
   wire logic signed [33:0] scaled = {{16{acc_step[17]}}, acc_step} <<<
      shift;
   wire logic [23:0] sat_result = (scaled > `RESULT_MAX) ? 24'h7fffff :
      (scaled < `RESULT_MIN) ? 24'h800000 : scaled[23:0];
   wire logic conv_done = step & osr_end;
   wire logic accept = conv_done & !hold;
   wire logic clr_filt = !filt_run & (mode != MODE_SLEEP);
   wire logic [OSR_W-1:0] nxt_osr_cnt = clr_filt ? '0 : !step ? osr_cnt_ff :
      osr_end ? '0 : osr_cnt_ff + OSR_W'(1);
   wire logic signed [17:0] nxt_acc = clr_filt ? 18'sd0 : !step ? acc_ff :
      osr_end ? 18'sd0 : acc_step;
   wire logic [23:0] nxt_result = accept ? sat_result : result_ff;

   // ----------------------------------------------------------------
   // register next values
   // ----------------------------------------------------------------
   wire logic nxt_done = accept | (wr_ctl1 ? (wdata[`CO_DONE] & done_flag) :
      done_flag);
   wire logic [7:0] nxt_control_one = {wr_ctl1 ? wdata[7:2] :
      control_one_ff[7:2], nxt_done, 1'b0};
   wire logic [7:0] nxt_control_zero = wr_ctl0 ? wdata : control_zero_ff;
   wire logic [7:0] nxt_channel_sel = wr_chan ? {2'b00, wdata[5:0]} :
      channel_sel_ff;
   wire logic [7:0] nxt_clock_divider = wr_cdiv ? {3'b000, wdata[4:0]} :
      clock_divider_ff;
   wire logic [7:0] nxt_reserved_tuning = wr_tune ? wdata :
      reserved_tuning_ff;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_pend_ff <= 1'b0;
         wr_idx_ff <= 8'h00;
         hrdata_ff <= 32'h00000000;
      end else if (ce_i) begin
         wr_pend_ff <= addr_phase & ahb_i.hwrite & idx_hit;
         wr_idx_ff <= req_idx;
         hrdata_ff <= nxt_hrdata;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         channel_sel_ff <= `RST_CHANNEL_SEL;
         control_zero_ff <= `RST_CONTROL_ZERO;
         control_one_ff <= `RST_CONTROL_ONE;
         clock_divider_ff <= `RST_CLOCK_DIVIDER;
         reserved_tuning_ff <= `RST_RESERVED_TUNING;
      end else if (ce_i) begin
         channel_sel_ff <= nxt_channel_sel;
         control_zero_ff <= nxt_control_zero;
         control_one_ff <= nxt_control_one;
         clock_divider_ff <= nxt_clock_divider;
         reserved_tuning_ff <= nxt_reserved_tuning;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         bit_sync_ff <= 3'b000;
         mod_bit_ff <= 1'b0;
         soft_reset_prev_ff <= 1'b0;
         started_ff <= 1'b0;
      end else if (ce_i) begin
         bit_sync_ff <= {bit_sync_ff[1:0], mod_bit_i};
         mod_bit_ff <= nxt_mod_bit;
         soft_reset_prev_ff <= soft_reset;
         started_ff <= nxt_started;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         osr_cnt_ff <= '0;
         acc_ff <= 18'sd0;
         result_ff <= 24'h000000;
         result_valid_ff <= 1'b0;
         analog_ff <= '0;
      end else if (ce_i) begin
         osr_cnt_ff <= nxt_osr_cnt;
         acc_ff <= nxt_acc;
         result_ff <= nxt_result;
         result_valid_ff <= accept;
         analog_ff <= nxt_analog;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign hreadyout_o = ce_i;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_ff;
   assign analog_o = analog_ff;
   assign result_valid_o = result_valid_ff;
   assign result_o = result_ff;
endmodule // sigma_delta_adc_control
`default_nettype wire

// ### verilog/sdadc_map.svh
// register offsets, field positions and reset values of the converter control
`ifndef SDADC_MAP_SVH
`define SDADC_MAP_SVH
// register indexes, byte address is four times the index
`define IDX_CHANNEL_SEL 8'h03
`define IDX_RESULT_LOW 8'h04
`define IDX_RESULT_MID 8'h05
`define IDX_RESULT_HIGH 8'h06
`define IDX_CONTROL_ZERO 8'h07
`define IDX_CONTROL_ONE 8'h08
`define IDX_CLOCK_DIVIDER 8'h09
`define IDX_RESERVED_TUNING 8'h0a
// reset values
`define RST_CHANNEL_SEL 8'h00
`define RST_CONTROL_ZERO 8'h20
`define RST_CONTROL_ONE 8'h00
`define RST_CLOCK_DIVIDER 8'h00
`define RST_RESERVED_TUNING 8'he4
// control zero fields
`define CZ_SOFT_RESET 7
`define CZ_SLEEP 6
`define CZ_POWER_OFF 5
`define CZ_OSR_HI 4
`define CZ_OSR_LO 1
`define CZ_REF_SEL 0
// control one fields
`define CO_FLMS_HI 7
`define CO_FLMS_LO 5
`define CO_NEG_BUF 4
`define CO_POS_BUF 3
`define CO_HOLD 2
`define CO_DONE 1
// channel select fields
`define CH_NEG_HI 5
`define CH_NEG_LO 3
`define CH_POS_HI 2
`define CH_POS_LO 0
`define CH_TEMP_SENSOR 3'h7
// filter ratio codes and divisors
`define FLMS_DIV30 3'h0
`define FLMS_DIV12 3'h2
`define RATIO_30 6'h1e
`define RATIO_12 6'h0c
// source divider
`define SRC_BYPASS 5'h1f
// oversampling
`define OSR_MAX_CODE 4'h8
`define OSR_TOP 16'h8000
`define SHIFT_BASE 5'h08
// result saturation limits
`define RESULT_MAX 34'sh007fffff
`define RESULT_MIN -34'sh00800000
`endif

// ### verilog/sdadc_pkg.sv
// types shared by the converter control design
package sdadc_pkg;
   typedef enum logic [1:0] {
      MODE_POWER_DOWN,
      MODE_SLEEP,
      MODE_NORMAL,
      MODE_RESET
   } conv_mode_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_req_t;

   typedef struct packed {
      logic bandgap_en;
      logic amp_en;
      logic modulator_en;
      logic temp_sensor_en;
      logic neg_ref_buffer_en;
      logic neg_ref_bypass;
      logic pos_ref_buffer_en;
      logic pos_ref_bypass;
      logic filter_en;
      logic filter_reset;
      logic reference_pair_sel;
   } analog_ctrl_t;
endpackage

// ### verilog/tick_divider.sv
// event divider that emits one tick per ratio advance events
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
   parameter int W = 6
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic advance_i,
   input wire logic [W-1:0] ratio_i,
   output logic tick_o
);
   logic [W-1:0] cnt_ff;
   logic tick_ff;
   wire logic at_end = (cnt_ff >= ratio_i - {{(W-1){1'b0}}, 1'b1});
   wire logic [W-1:0] nxt_cnt = !run_i ? '0 :
      !advance_i ? cnt_ff : at_end ? '0 : cnt_ff + {{(W-1){1'b0}}, 1'b1};
   wire logic nxt_tick = run_i & advance_i & at_end;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (ce_i) begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick_o = tick_ff;
endmodule // tick_divider
`default_nettype wire

// ### verif/sdadc_checker.sv
// port assertions for the converter control
`timescale 1ns/1ns
`default_nettype none
module sdadc_checker #(
   parameter int DIV_W = 6,
   parameter int OSR_W = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire sdadc_pkg::ahb_req_t ahb_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] hrdata_o,
   input wire sdadc_pkg::analog_ctrl_t analog_o,
   input wire logic result_valid_o,
   input wire logic [23:0] result_o
);
   import sdadc_pkg::*;
   logic rd_take;
   logic bad_addr;
   assign rd_take = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1]
      && !ahb_i.hwrite && ce_i;
   assign bad_addr = ahb_i.haddr[1:0] != 2'h0
      || ahb_i.haddr[31:2] < 30'h3 || ahb_i.haddr[31:2] > 30'ha;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_bad_read;
      rd_take ##0 bad_addr;
   endsequence
   property p_bus_ok;
      hreadyout_o == ce_i && !hresp_o;
   endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus answer");
   property p_bad_zero;
      s_bad_read |=> hrdata_o == 32'h0;
   endproperty
   a_bad_zero: assert property (p_bad_zero) else $error("bad read");
   property p_idle_zero;
      !rd_take && ce_i |=> hrdata_o == 32'h0 ##1 hrdata_o[31:8] == 24'h0;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("rdata");
   property p_pd;
      !analog_o.bandgap_en |-> !(analog_o.amp_en || analog_o.modulator_en
         || analog_o.temp_sensor_en || analog_o.filter_en
         || analog_o.neg_ref_buffer_en || analog_o.pos_ref_buffer_en);
   endproperty
   a_pd: assert property (p_pd) else $error("power down");
   property p_sleep;
      analog_o.filter_en && !analog_o.modulator_en |-> analog_o.bandgap_en
         && analog_o.amp_en && !analog_o.temp_sensor_en
         && analog_o.neg_ref_bypass && analog_o.pos_ref_bypass;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep");
   property p_rst_mode;
      analog_o.filter_reset |-> analog_o.bandgap_en && analog_o.modulator_en;
   endproperty
   a_rst_mode: assert property (p_rst_mode) else $error("rst mode");
   property p_neg_buf;
      !$past(reset_i) |->
         analog_o.neg_ref_buffer_en != analog_o.neg_ref_bypass;
   endproperty
   a_neg_buf: assert property (p_neg_buf) else $error("neg buffer");
   property p_pos_buf;
      !$past(reset_i) |->
         analog_o.pos_ref_buffer_en != analog_o.pos_ref_bypass;
   endproperty
   a_pos_buf: assert property (p_pos_buf) else $error("pos buffer");
   property p_temp;
      analog_o.temp_sensor_en |-> analog_o.modulator_en;
   endproperty
   a_temp: assert property (p_temp) else $error("temp sensor");
   property p_hold;
      !result_valid_o |-> $stable(result_o);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_run;
      result_valid_o |-> $past(analog_o.modulator_en)
         && !$past(analog_o.filter_reset);
   endproperty
   a_run: assert property (p_run) else $error("stray result");
endmodule // sdadc_checker
bind sigma_delta_adc_control sdadc_checker #(.DIV_W(DIV_W), .OSR_W(OSR_W))
   u_checker (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .ahb_i(ahb_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
   .analog_o(analog_o), .result_valid_o(result_valid_o),
   .result_o(result_o));
`default_nettype wire

// ### verif/sigma_delta_adc_control_test.sv
// self-checking bench for the converter control
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_map.svh"
module sigma_delta_adc_control_test;
   import sdadc_pkg::*;
   logic clk_i, reset_i, ce_i, mod_bit_i, hsel, hwrite, m;
   logic hreadyout_o, hresp_o, result_valid_o;
   logic [31:0] haddr, hwdata, hrdata_o;
   logic [1:0] htrans;
   logic [23:0] result_o, e;
   logic [7:0] rd, c0, c1, ch;
   ahb_req_t req;
   analog_ctrl_t analog_o;
   int fail_count = 0;
   int comparisons = 0;
   int n;
   logic [7:0] ri [5] = '{`IDX_CHANNEL_SEL, `IDX_CONTROL_ZERO,
      `IDX_CONTROL_ONE, `IDX_CLOCK_DIVIDER, `IDX_RESERVED_TUNING};
   logic [7:0] rv [5] = '{`RST_CHANNEL_SEL, `RST_CONTROL_ZERO,
      `RST_CONTROL_ONE, `RST_CLOCK_DIVIDER, `RST_RESERVED_TUNING};
   logic [4:0] ks [4] = '{5'h1f, 5'h1f, 5'h00, 5'h1f};
   logic [2:0] fs [4] = '{3'h0, 3'h2, 3'h2, 3'h2};
   logic [3:0] os [4] = '{4'h8, 4'h8, 4'h8, 4'h7};
   assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout_o};
   sigma_delta_adc_control #(.DIV_W(6), .OSR_W(16)) uut (.clk_i(clk_i),
      .reset_i(reset_i), .ce_i(ce_i), .ahb_i(req), .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o), .hrdata_o(hrdata_o), .mod_bit_i(mod_bit_i),
      .analog_o(analog_o), .result_valid_o(result_valid_o),
      .result_o(result_o));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // ------------------------------
   // tasks and expectations
   // ------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o[7:0];
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk({24'h0, rd}, {24'h0, exp});
   endtask
   task automatic wait_valid(output int c);
      c = 0;
      do begin
         @(posedge clk_i);
         c++;
      end while (result_valid_o !== 1'b1);
   endtask
   task automatic count_valid(input int cyc, output int c);
      c = 0;
      repeat (cyc) begin
         @(posedge clk_i);
         if (result_valid_o === 1'b1) c++;
      end
   endtask
   function automatic int period(input logic [4:0] k, input logic [2:0] f,
      input logic [3:0] o);
      return (f == 3'h0 ? 30 : 12) * (k == 5'h1f ? 1 : 2 * (k + 1))
         * (32768 >> o);
   endfunction
   function automatic analog_ctrl_t exp_an(input logic [7:0] z, o, h);
      analog_ctrl_t a;
      logic on;
      on = !z[5] && !z[6];
      a.bandgap_en = !z[5];
      a.amp_en = !z[5];
      a.filter_en = !z[5];
      a.modulator_en = on;
      a.filter_reset = on && z[7];
      a.temp_sensor_en = on && (h[5:3] == 3'h7 || h[2:0] == 3'h7);
      a.neg_ref_buffer_en = on && o[4];
      a.neg_ref_bypass = !(on && o[4]);
      a.pos_ref_buffer_en = on && o[3];
      a.pos_ref_bypass = !(on && o[3]);
      a.reference_pair_sel = z[0];
      return a;
   endfunction
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      fail_count++;
      finish_test();
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      void'($urandom(32'h4592));
      {reset_i, ce_i, mod_bit_i, hsel, hwrite} = 5'b11000;
      {haddr, hwdata, htrans} = '0;
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({21'h0, analog_o}, {21'h0, exp_an(8'h20, 8'h0, 8'h0)});
      for (int i = 0; i < 5; i++) rchk(ri[i], rv[i]);
      wr(`IDX_RESERVED_TUNING, 8'he7);
      rchk(`IDX_RESERVED_TUNING, 8'he7);
      for (int i = 3; i < 10; i++) wr(8'(i), 8'hff);
      rchk(`IDX_CHANNEL_SEL, 8'h3f);
      rchk(`IDX_CONTROL_ONE, 8'hfc);
      rchk(`IDX_CLOCK_DIVIDER, 8'h1f);
      rchk(`IDX_RESULT_LOW, 8'h00);
      rchk(8'h0b, 8'h00);
      ce_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, hreadyout_o}, 32'h0);
      chk({31'h0, hresp_o}, 32'h0);
      ce_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         c1 = {3'h2, 2'($urandom), 3'h0};
         ch = 8'($urandom) & 8'h3f;
         if (i == 0) ch[2:0] = 3'h7;
         if (i == 4) ch[5:3] = 3'h7;
         c0 = {i[2:0], 4'h8, 1'($urandom) & ~i[0]};
         wr(`IDX_CHANNEL_SEL, ch);
         wr(`IDX_CONTROL_ONE, c1);
         wr(`IDX_CONTROL_ZERO, c0);
         repeat (2) @(posedge clk_i);
         chk({21'h0, analog_o}, {21'h0, exp_an(c0, c1, ch)});
         rchk(`IDX_CONTROL_ZERO, c0);
      end
      for (int j = 0; j < 4; j++) begin
         m = 1'($urandom);
         mod_bit_i <= m;
         e = m ? 24'h7fffff : 24'h800000;
         wr(`IDX_CLOCK_DIVIDER, {3'h0, ks[j]});
         wr(`IDX_CONTROL_ONE, {fs[j], 5'h0});
         wr(`IDX_CONTROL_ZERO, {3'h4, os[j], 1'b0});
         wr(`IDX_CONTROL_ZERO, {3'h0, os[j], 1'b0});
         wait_valid(n);
         wait_valid(n);
         chk(32'(n), 32'(period(ks[j], fs[j], os[j])));
         chk({8'h0, result_o}, {8'h0, e});
         rchk(`IDX_CONTROL_ONE, {fs[j], 5'h2});
         wr(`IDX_CONTROL_ONE, {fs[j], 5'h06});
         for (int k = 0; k < 3; k++) begin
            rchk(8'h04 + 8'(k), e[8*k +: 8]);
         end
         wr(`IDX_CONTROL_ONE, {fs[j], 5'h02});
      end
      wr(`IDX_CONTROL_ONE, 8'h44);
      mod_bit_i <= !m;
      count_valid(7000, n);
      chk(32'(n), 32'h0);
      rchk(`IDX_CONTROL_ONE, 8'h44);
      rchk(`IDX_RESULT_HIGH, e[23:16]);
      wr(`IDX_CONTROL_ONE, 8'h40);
      wait_valid(n);
      chk({8'h0, result_o}, {8'h0, ~e});
      repeat (1500) @(posedge clk_i);
      wr(`IDX_CONTROL_ZERO, 8'h8e);
      count_valid(4000, n);
      chk(32'(n), 32'h0);
      wr(`IDX_CONTROL_ZERO, 8'h0e);
      wait_valid(n);
      chk({31'h0, n > 2800}, 32'h1);
      wr(`IDX_CONTROL_ZERO, 8'h4e);
      count_valid(4000, n);
      chk(32'(n), 32'h0);
      wr(`IDX_CONTROL_ONE, 8'h20);
      wr(`IDX_CONTROL_ZERO, 8'h10);
      count_valid(4000, n);
      chk(32'(n), 32'h0);
      finish_test();
   end
endmodule // sigma_delta_adc_control_test
`default_nettype wire
